// ===== rtl/dbcd_pkg.sv
// Constants and types shared by the disk block command decoder.
package dbcd_pkg;

  localparam logic [7:0] OP_READ = 8'h08;
  localparam logic [7:0] OP_WRITE = 8'h0A;
  localparam logic [7:0] OP_SEEK = 8'h0B;
  localparam logic [7:0] OP_USAGE = 8'h11;
  localparam logic [7:0] OP_INQUIRY = 8'h12;

  localparam int LUN_MSB = 7;
  localparam int LUN_LSB = 5;
  localparam int LBA_HI_MSB = 4;
  localparam int FLAG_BIT = 1;
  localparam int LINK_BIT = 0;
  localparam int LBA_W = 21;

  localparam int CNT_W = 9;
  localparam logic [8:0] ZERO_LEN_BLOCKS = 9'h100;
  localparam logic [8:0] ONE_BLOCK = 9'h001;

  localparam int BIG_CNT_W = 24;
  localparam int ERR_CNT_W = 8;
  localparam int RPT_W = 72;
  localparam logic [3:0] RPT_LAST_IDX = 4'h8;

  localparam int INQ_HDR_BYTES = 5;
  localparam int INQ_BYTES = 58;
  localparam int INQ_AW = 6;

  localparam logic [20:0] LBA_RST = 21'h000000;
  localparam logic [71:0] RPT_RST = 72'h0;

  typedef struct packed {
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
    logic [7:0] b5;
  } dbcd_cdb_t;

  typedef struct packed {
    logic blk_read;
    logic seek_move;
    logic corr_err;
    logic uncorr_err;
    logic seek_err;
  } dbcd_ev_t;

  typedef enum logic [1:0] {
    MED_READ = 2'b00,
    MED_WRITE = 2'b01,
    MED_SEEK = 2'b10
  } dbcd_med_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_XFER = 3'b001,
    ST_SEEK = 3'b010,
    ST_RPT = 3'b011,
    ST_IFETCH = 3'b100,
    ST_ILOAD = 3'b101,
    ST_ITX = 3'b110,
    ST_STAT = 3'b111
  } dbcd_state_t;

endpackage

// ===== rtl/dbcd_counter.sv
// Usage or error counter with sticky overflow flag.
module dbcd_counter #(
  parameter int W = 8
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic inc,
  input wire logic clr,
  output logic [W-1:0] value,
  output logic ovf
);

  logic [W-1:0] val_r;
  logic [W-1:0] val_nxt;
  logic [W-1:0] base;
  logic ovf_r;
  logic ovf_nxt;

  // An event in the clearing cycle still counts once
  always_comb begin
    base = clr ? '0 : val_r;
    val_nxt = base + {{(W-1){1'b0}}, inc};
    ovf_nxt = (clr ? 1'b0 : ovf_r) | (inc & (&base));
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      val_r <= '0;
      ovf_r <= 1'b0;
    end else begin
      val_r <= val_nxt;
      ovf_r <= ovf_nxt;
    end
  end

  assign value = val_r;
  assign ovf = ovf_r;

endmodule

// ===== rtl/dbcd_inq_mem.sv
// Inquiry data store with registered read port.
module dbcd_inq_mem #(
  parameter int DEPTH = 58,
  parameter int AW = 6
) (
  input wire logic mclk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);

  logic [7:0] mem [DEPTH];
  logic [7:0] q_r;

  // No reset on storage; contents are loaded before use
  always_ff @(posedge mclk) begin
    if (wr_en && (int'(wr_addr) < DEPTH)) begin
      mem[wr_addr] <= wr_data;
    end
    q_r <= (int'(rd_addr) < DEPTH) ? mem[rd_addr] : 8'h00;
  end

  assign rd_data = q_r;

endmodule

// ===== rtl/dbcd_top.sv
// Six-byte disk command decoder and executor.
// Functional notes
// - Opcode 08h reads blocks to initiator
// - Read starts at given block, then consecutive
// - Transfer length zero means 256 blocks
// - Opcode 0Ah writes initiator data to medium
// - Write from given block until count used
// - Opcode 0Bh seeks without data; byte4 reserved
// - Byte1 holds unit and high address bits
// - Opcode 11h reports five usage counters
// - Counter report clears all counters afterwards
// - Nine report bytes, most significant first
// - Enabled overflow fails next command, sense holds
// - Sense retrieval resets the usage counters
// - Overflow reporting mode bit, off at reset
// - Opcode 12h returns inquiry data
// - Zero allocation length: no data, no error
// - Inquiry ends at allocation or data end
// - Inquiry data unavailable gives check condition
// - Inquiry data starts with five-byte header
// - Overflow enable bit defaults to zero
module dbcd_top #(
  parameter int INQ_BYTES = dbcd_pkg::INQ_BYTES,
  parameter int INQ_AW = dbcd_pkg::INQ_AW
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic cdb_valid,
  output logic cdb_ready,
  input wire dbcd_pkg::dbcd_cdb_t cdb,
  output logic [2:0] cmd_lun,
  output logic cmd_flag,
  output logic cmd_link,
  output logic cmd_done,
  output logic cmd_check,
  input wire logic mode_wr,
  input wire logic mode_usage_en,
  output logic usage_en,
  output logic med_req,
  output dbcd_pkg::dbcd_med_op_t med_op,
  output logic [dbcd_pkg::LBA_W-1:0] med_lba,
  input wire logic med_done,
  input wire dbcd_pkg::dbcd_ev_t ev,
  output logic din_valid,
  input wire logic din_ready,
  output logic [7:0] din_data,
  input wire logic inq_avail,
  input wire logic inq_wr_en,
  input wire logic [INQ_AW-1:0] inq_wr_addr,
  input wire logic [7:0] inq_wr_data,
  output logic sense_valid,
  output logic [dbcd_pkg::RPT_W-1:0] sense_cnt,
  input wire logic sense_taken
);

  localparam logic [7:0] INQ_LAST = 8'(INQ_BYTES);

  dbcd_pkg::dbcd_state_t state_r;
  dbcd_pkg::dbcd_state_t state_nxt;
  dbcd_pkg::dbcd_med_op_t op_r;
  dbcd_pkg::dbcd_med_op_t op_nxt;
  logic [dbcd_pkg::LBA_W-1:0] lba_r;
  logic [dbcd_pkg::LBA_W-1:0] lba_nxt;
  logic [dbcd_pkg::CNT_W-1:0] left_r;
  logic [dbcd_pkg::CNT_W-1:0] left_nxt;
  logic [dbcd_pkg::RPT_W-1:0] rpt_r;
  logic [dbcd_pkg::RPT_W-1:0] rpt_nxt;
  logic [dbcd_pkg::RPT_W-1:0] sense_r;
  logic [dbcd_pkg::RPT_W-1:0] sense_nxt;
  logic [7:0] idx_r;
  logic [7:0] idx_nxt;
  logic [7:0] icount_r;
  logic [7:0] icount_nxt;
  logic [2:0] lun_r;
  logic [2:0] lun_nxt;
  logic flag_r;
  logic flag_nxt;
  logic link_r;
  logic link_nxt;
  logic done_r;
  logic done_nxt;
  logic check_r;
  logic check_nxt;
  logic sense_valid_r;
  logic sense_valid_nxt;
  logic usage_en_r;
  logic usage_en_nxt;
  logic cnt_clr;
  logic rpt_clr;
  logic ovf_pend;

  logic [dbcd_pkg::BIG_CNT_W-1:0] blk_cnt;
  logic [dbcd_pkg::BIG_CNT_W-1:0] seek_cnt;
  logic [dbcd_pkg::ERR_CNT_W-1:0] unc_cnt;
  logic [dbcd_pkg::ERR_CNT_W-1:0] cor_cnt;
  logic [dbcd_pkg::ERR_CNT_W-1:0] serr_cnt;
  logic [4:0] ovf_v;
  logic [dbcd_pkg::RPT_W-1:0] cnt_vec;
  logic [7:0] mem_q;
  logic [dbcd_pkg::LBA_W-1:0] cdb_lba;
  logic [7:0] cdb_len;

  dbcd_counter #(.W(dbcd_pkg::BIG_CNT_W)) u_blk (
    .mclk(mclk), .srst(srst), .inc(ev.blk_read), .clr(cnt_clr),
    .value(blk_cnt), .ovf(ovf_v[4])
  );
  dbcd_counter #(.W(dbcd_pkg::BIG_CNT_W)) u_seek (
    .mclk(mclk), .srst(srst), .inc(ev.seek_move), .clr(cnt_clr),
    .value(seek_cnt), .ovf(ovf_v[3])
  );
  dbcd_counter #(.W(dbcd_pkg::ERR_CNT_W)) u_unc (
    .mclk(mclk), .srst(srst), .inc(ev.uncorr_err), .clr(cnt_clr),
    .value(unc_cnt), .ovf(ovf_v[2])
  );
  dbcd_counter #(.W(dbcd_pkg::ERR_CNT_W)) u_cor (
    .mclk(mclk), .srst(srst), .inc(ev.corr_err), .clr(cnt_clr),
    .value(cor_cnt), .ovf(ovf_v[1])
  );
  dbcd_counter #(.W(dbcd_pkg::ERR_CNT_W)) u_serr (
    .mclk(mclk), .srst(srst), .inc(ev.seek_err), .clr(cnt_clr),
    .value(serr_cnt), .ovf(ovf_v[0])
  );

  dbcd_inq_mem #(.DEPTH(INQ_BYTES), .AW(INQ_AW)) u_inq (
    .mclk(mclk),
    .wr_en(inq_wr_en),
    .wr_addr(inq_wr_addr),
    .wr_data(inq_wr_data),
    .rd_addr(idx_r[INQ_AW-1:0]),
    .rd_data(mem_q)
  );

  // Byte order of the report and of the sense copy
  assign cnt_vec = {blk_cnt, seek_cnt, unc_cnt, cor_cnt, serr_cnt};

  // Address and length fields of the command block
  assign cdb_lba = {cdb.b1[dbcd_pkg::LBA_HI_MSB:0], cdb.b2, cdb.b3};
  assign cdb_len = cdb.b4;

  assign ovf_pend = usage_en_r & (|ovf_v);

  // Report end and sense retrieval both empty the counters
  assign rpt_clr = (state_r == dbcd_pkg::ST_RPT) & din_ready &
                   (idx_r[3:0] == dbcd_pkg::RPT_LAST_IDX);
  assign cnt_clr = rpt_clr | (sense_taken & sense_valid_r);

  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    lba_nxt = lba_r;
    left_nxt = left_r;
    rpt_nxt = rpt_r;
    sense_nxt = sense_r;
    idx_nxt = idx_r;
    icount_nxt = icount_r;
    lun_nxt = lun_r;
    flag_nxt = flag_r;
    link_nxt = link_r;
    done_nxt = 1'b0;
    check_nxt = check_r;
    sense_valid_nxt = sense_valid_r;
    usage_en_nxt = usage_en_r;
    if (mode_wr) begin
      usage_en_nxt = mode_usage_en;
    end
    if (sense_taken && sense_valid_r) begin
      sense_valid_nxt = 1'b0;
    end
    case (state_r)
      dbcd_pkg::ST_IDLE: begin
        if (cdb_valid) begin
          lun_nxt = cdb.b1[dbcd_pkg::LUN_MSB:dbcd_pkg::LUN_LSB];
          flag_nxt = cdb.b5[dbcd_pkg::FLAG_BIT];
          link_nxt = cdb.b5[dbcd_pkg::LINK_BIT];
          check_nxt = 1'b0;
          idx_nxt = 8'h00;
          lba_nxt = cdb_lba;
          left_nxt = (cdb_len == 8'h00) ? dbcd_pkg::ZERO_LEN_BLOCKS :
                     {1'b0, cdb_len};
          if (ovf_pend && !sense_valid_r) begin
            // The failed command is not executed at all
            sense_nxt = cnt_vec;
            sense_valid_nxt = 1'b1;
            check_nxt = 1'b1;
            state_nxt = dbcd_pkg::ST_STAT;
          end else begin
            case (cdb.b0)
              dbcd_pkg::OP_READ: begin
                op_nxt = dbcd_pkg::MED_READ;
                state_nxt = dbcd_pkg::ST_XFER;
              end
              dbcd_pkg::OP_WRITE: begin
                op_nxt = dbcd_pkg::MED_WRITE;
                state_nxt = dbcd_pkg::ST_XFER;
              end
              dbcd_pkg::OP_SEEK: begin
                // Byte 4 is ignored here
                op_nxt = dbcd_pkg::MED_SEEK;
                state_nxt = dbcd_pkg::ST_SEEK;
              end
              dbcd_pkg::OP_USAGE: begin
                rpt_nxt = cnt_vec;
                state_nxt = dbcd_pkg::ST_RPT;
              end
              dbcd_pkg::OP_INQUIRY: begin
                if (cdb_len == 8'h00) begin
                  state_nxt = dbcd_pkg::ST_STAT;
                end else if (!inq_avail) begin
                  check_nxt = 1'b1;
                  state_nxt = dbcd_pkg::ST_STAT;
                end else begin
                  icount_nxt = (cdb_len < INQ_LAST) ? cdb_len :
                               INQ_LAST;
                  state_nxt = dbcd_pkg::ST_IFETCH;
                end
              end
              default: begin
                check_nxt = 1'b1;
                state_nxt = dbcd_pkg::ST_STAT;
              end
            endcase
          end
        end
      end
      dbcd_pkg::ST_XFER: begin
        if (med_done) begin
          lba_nxt = lba_r + 21'h000001;
          left_nxt = left_r - dbcd_pkg::ONE_BLOCK;
          if (left_r == dbcd_pkg::ONE_BLOCK) begin
            state_nxt = dbcd_pkg::ST_STAT;
          end
        end
      end
      dbcd_pkg::ST_SEEK: begin
        if (med_done) begin
          state_nxt = dbcd_pkg::ST_STAT;
        end
      end
      dbcd_pkg::ST_RPT: begin
        if (din_ready) begin
          rpt_nxt = {rpt_r[dbcd_pkg::RPT_W-9:0], 8'h00};
          idx_nxt = idx_r + 8'h01;
          if (rpt_clr) begin
            state_nxt = dbcd_pkg::ST_STAT;
          end
        end
      end
      dbcd_pkg::ST_IFETCH: begin
        // Memory read takes one cycle, so each byte costs at least three
        state_nxt = dbcd_pkg::ST_ILOAD;
      end
      dbcd_pkg::ST_ILOAD: begin
        // Streaming from address zero keeps the header first
        rpt_nxt = {mem_q, rpt_r[dbcd_pkg::RPT_W-9:0]};
        state_nxt = dbcd_pkg::ST_ITX;
      end
      dbcd_pkg::ST_ITX: begin
        if (din_ready) begin
          idx_nxt = idx_r + 8'h01;
          if (idx_r == icount_r - 8'h01) begin
            state_nxt = dbcd_pkg::ST_STAT;
          end else begin
            state_nxt = dbcd_pkg::ST_IFETCH;
          end
        end
      end
      dbcd_pkg::ST_STAT: begin
        done_nxt = 1'b1;
        state_nxt = dbcd_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = dbcd_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_r <= dbcd_pkg::ST_IDLE;
      op_r <= dbcd_pkg::MED_READ;
      lba_r <= dbcd_pkg::LBA_RST;
      left_r <= '0;
      rpt_r <= dbcd_pkg::RPT_RST;
      sense_r <= dbcd_pkg::RPT_RST;
      idx_r <= 8'h00;
      icount_r <= 8'h00;
      lun_r <= 3'h0;
      flag_r <= 1'b0;
      link_r <= 1'b0;
      done_r <= 1'b0;
      check_r <= 1'b0;
      sense_valid_r <= 1'b0;
      usage_en_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      lba_r <= lba_nxt;
      left_r <= left_nxt;
      rpt_r <= rpt_nxt;
      sense_r <= sense_nxt;
      idx_r <= idx_nxt;
      icount_r <= icount_nxt;
      lun_r <= lun_nxt;
      flag_r <= flag_nxt;
      link_r <= link_nxt;
      done_r <= done_nxt;
      check_r <= check_nxt;
      sense_valid_r <= sense_valid_nxt;
      usage_en_r <= usage_en_nxt;
    end
  end

  assign cdb_ready = (state_r == dbcd_pkg::ST_IDLE);
  assign med_req = (state_r == dbcd_pkg::ST_XFER) |
                   (state_r == dbcd_pkg::ST_SEEK);
  assign med_op = op_r;
  assign med_lba = lba_r;
  assign din_valid = (state_r == dbcd_pkg::ST_RPT) |
                     (state_r == dbcd_pkg::ST_ITX);
  assign din_data = rpt_r[dbcd_pkg::RPT_W-1:dbcd_pkg::RPT_W-8];
  assign cmd_lun = lun_r;
  assign cmd_flag = flag_r;
  assign cmd_link = link_r;
  assign cmd_done = done_r;
  assign cmd_check = check_r;
  assign usage_en = usage_en_r;
  assign sense_valid = sense_valid_r;
  assign sense_cnt = sense_r;

endmodule

// ===== verification/dbcd_chk.sv
// Port assertions for the disk block command decoder.
module dbcd_chk (
  input wire logic mclk,
  input wire logic srst,
  input wire logic cdb_valid,
  input wire logic cdb_ready,
  input wire dbcd_pkg::dbcd_cdb_t cdb,
  input wire logic [2:0] cmd_lun,
  input wire logic cmd_flag,
  input wire logic cmd_link,
  input wire logic cmd_done,
  input wire logic cmd_check,
  input wire logic mode_wr,
  input wire logic mode_usage_en,
  input wire logic usage_en,
  input wire logic med_req,
  input wire dbcd_pkg::dbcd_med_op_t med_op,
  input wire logic [20:0] med_lba,
  input wire logic med_done,
  input wire logic din_valid,
  input wire logic din_ready,
  input wire logic [7:0] din_data,
  input wire logic inq_avail,
  input wire logic sense_valid,
  input wire logic sense_taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tk;
  logic ok;
  logic mv;
  logic [7:0] op;
  logic [20:0] lba;
  dbcd_pkg::dbcd_med_op_t eop;
  // Overflow failure needs the enable, so clean takes exclude it
  assign tk = cdb_valid && cdb_ready;
  assign ok = tk && !usage_en;
  assign op = cdb.b0;
  assign lba = {cdb.b1[4:0], cdb.b2, cdb.b3};
  assign mv = op == dbcd_pkg::OP_READ || op == dbcd_pkg::OP_WRITE
    || op == dbcd_pkg::OP_SEEK;
  assign eop = op == dbcd_pkg::OP_READ ? dbcd_pkg::MED_READ
    : op == dbcd_pkg::OP_WRITE ? dbcd_pkg::MED_WRITE : dbcd_pkg::MED_SEEK;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (srst);
  property p_go;
    ok && mv |=> med_req && med_op == $past(eop) && med_lba == $past(lba);
  endproperty
  a_go: assert property (p_go)
    else $error("medium start wrong");
  property p_step;
    med_req && med_done && med_op != dbcd_pkg::MED_SEEK
      |=> med_lba == $past(med_lba) + 21'h000001;
  endproperty
  a_step: assert property (p_step)
    else $error("block address not advanced");
  property p_sk_end;
    med_req && med_done && med_op == dbcd_pkg::MED_SEEK
      |=> !med_req ##1 cmd_done;
  endproperty
  a_sk_end: assert property (p_sk_end)
    else $error("seek did not finish");
  property p_unit;
    tk |=> cmd_lun == $past(cdb.b1[7:5]) && cmd_flag == $past(cdb.b5[1])
      && cmd_link == $past(cdb.b5[0]);
  endproperty
  a_unit: assert property (p_unit)
    else $error("unit or flag fields wrong");
  property p_inq0;
    ok && op == dbcd_pkg::OP_INQUIRY && cdb.b4 == 8'h00 && inq_avail
      |=> !din_valid && !cmd_done ##1 cmd_done && !cmd_check;
  endproperty
  a_inq0: assert property (p_inq0)
    else $error("zero length inquiry wrong");
  property p_inq_na;
    ok && op == dbcd_pkg::OP_INQUIRY && cdb.b4 != 8'h00 && !inq_avail
      |=> !din_valid ##1 cmd_done && cmd_check;
  endproperty
  a_inq_na: assert property (p_inq_na)
    else $error("missing inquiry data not flagged");
  property p_hold;
    din_valid && !din_ready |=> din_valid && $stable(din_data);
  endproperty
  a_hold: assert property (p_hold)
    else $error("data byte dropped before accept");
  property p_mode;
    mode_wr |=> usage_en == $past(mode_usage_en);
  endproperty
  a_mode: assert property (p_mode)
    else $error("overflow enable not loaded");
  c_len0: cover property (tk && op == dbcd_pkg::OP_READ && cdb.b4 == 8'h00);
  c_rpt: cover property (tk && op == dbcd_pkg::OP_USAGE);
  c_sense: cover property (sense_valid && sense_taken);
endmodule

bind dbcd_top dbcd_chk i_chk (.mclk, .srst, .cdb_valid, .cdb_ready, .cdb,
  .cmd_lun, .cmd_flag, .cmd_link, .cmd_done, .cmd_check, .mode_wr,
  .mode_usage_en, .usage_en, .med_req, .med_op, .med_lba, .med_done,
  .din_valid, .din_ready, .din_data, .inq_avail, .sense_valid,
  .sense_taken);

// ===== verification/dbcd_host_model.sv
// Initiator and medium stand-in answering block steps and data bytes.
module dbcd_host_model (
  input wire logic mclk,
  input wire logic srst,
  input wire logic slow,
  input wire logic med_req,
  input wire logic din_valid,
  output logic med_done,
  output logic din_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] w_r;
  logic [2:0] w_nxt;
  logic md_nxt;
  logic dr_nxt;
  // Slow mode stalls both answers so held outputs get exercised
  always_comb begin
    w_nxt = w_r + 3'h1;
    md_nxt = med_req && !med_done && (!slow || w_r == 3'h0);
    dr_nxt = din_valid && !din_ready && (!slow || w_r[0]);
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      w_r <= 3'h0;
      med_done <= 1'b0;
      din_ready <= 1'b0;
    end else begin
      w_r <= w_nxt;
      med_done <= md_nxt;
      din_ready <= dr_nxt;
    end
  end
endmodule

// ===== verification/disk_block_command_decoder_bench.sv
// Self-checking bench for the disk block command decoder.
module disk_block_command_decoder_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, srst, cdb_valid, cdb_ready, cmd_flag, cmd_link, cmd_done;
  logic cmd_check, mode_wr, mode_usage_en, usage_en, med_req, med_done;
  logic din_valid, din_ready, inq_avail, inq_wr_en, sense_valid;
  logic sense_taken, slow;
  logic [2:0] cmd_lun;
  logic [5:0] inq_wr_addr;
  logic [7:0] din_data, inq_wr_data;
  logic [20:0] med_lba;
  logic [71:0] sense_cnt, exp_cnt;
  dbcd_pkg::dbcd_cdb_t cdb;
  dbcd_pkg::dbcd_med_op_t med_op;
  dbcd_pkg::dbcd_ev_t ev;
  int seed, num_errors, checks, nblk, len;
  int alen [7] = '{0, 1, 5, 57, 58, 59, 255};
  logic [7:0] ops [3];
  logic [7:0] mem [58];
  logic [7:0] got [$];

  dbcd_top i_dut (.mclk, .srst, .cdb_valid, .cdb_ready, .cdb, .cmd_lun,
    .cmd_flag, .cmd_link, .cmd_done, .cmd_check, .mode_wr, .mode_usage_en,
    .usage_en, .med_req, .med_op, .med_lba, .med_done, .ev, .din_valid,
    .din_ready, .din_data, .inq_avail, .inq_wr_en, .inq_wr_addr,
    .inq_wr_data, .sense_valid, .sense_cnt, .sense_taken);
  dbcd_host_model i_host (.mclk, .srst, .slow, .med_req, .din_valid,
    .med_done, .din_ready);

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Sampled mid-cycle, where the coming edge's handshake has settled
  always @(negedge mclk) begin
    if (med_req === 1'b1 && med_done === 1'b1)
      nblk++;
    if (din_valid === 1'b1 && din_ready === 1'b1)
      got.push_back(din_data);
  end

  task automatic chk(input logic [71:0] g, input logic [71:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR at %0t: got %h, expected %h", $time, g, e);
    end
  endtask

  function automatic int exp_blocks(input logic [7:0] ln);
    return (ln == 8'h00) ? 256 : int'(ln);
  endfunction

  function automatic int exp_inq(input int a);
    return (a < dbcd_pkg::INQ_BYTES) ? a : dbcd_pkg::INQ_BYTES;
  endfunction

  // Offered in the done cycle of the previous command: tightest spacing
  task automatic run(input logic [47:0] c);
    int n;
    n = 0;
    got.delete();
    nblk = 0;
    cdb = c;
    cdb_valid = 1'b1;
    slow = 1'($random(seed));
    @(negedge mclk);
    cdb_valid = 1'b0;
    cdb = 48'($random(seed));
    while (cmd_done !== 1'b1 && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 5000) begin
      num_errors++;
      $display("ERROR at %0t: no done, got %h, expected %h", $time,
        cmd_done, 1'b1);
    end
  endtask

  task automatic blk(input logic [7:0] op, input logic [7:0] ln);
    logic [2:0] u;
    logic [20:0] a;
    logic [1:0] f;
    u = 3'($random(seed));
    a = 21'($random(seed));
    f = 2'($random(seed));
    run({op, u, a, ln, 6'h00, f});
    len = exp_blocks(ln);
    if (op == dbcd_pkg::OP_SEEK)
      len = 1;
    chk(nblk, len);
    if (op == dbcd_pkg::OP_SEEK)
      len = 0;
    chk(med_lba, 21'(a + len));
    chk(cmd_lun, u);
    chk({cmd_flag, cmd_link}, f);
    chk(cmd_check, 0);
  endtask

  task automatic report(input logic [71:0] e);
    logic [71:0] r;
    r = 72'h0;
    run({dbcd_pkg::OP_USAGE, 40'h0});
    foreach (got[k])
      r = {r[63:0], got[k]};
    chk(got.size(), 9);
    chk(r, e);
  endtask

  // Forced bits plus random bits; the expected counts follow each cycle
  task automatic pulse(input int n, input logic [4:0] m, input logic [4:0] r);
    repeat (n) begin
      @(negedge mclk);
      ev = m | (5'($random(seed)) & r);
      exp_cnt[71:48] += 24'(ev.blk_read);
      exp_cnt[47:24] += 24'(ev.seek_move);
      exp_cnt[23:16] += 8'(ev.uncorr_err);
      exp_cnt[15:8] += 8'(ev.corr_err);
      exp_cnt[7:0] += 8'(ev.seek_err);
    end
    @(negedge mclk);
    ev = 5'h00;
  endtask

  task automatic give_verdict();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    num_errors++;
    give_verdict();
  end

  initial begin
    seed = 32'hBE0B;
    num_errors = 0;
    checks = 0;
    nblk = 0;
    exp_cnt = 72'h0;
    srst = 1'b1;
    cdb_valid = 1'b0;
    cdb = 48'h0;
    mode_wr = 1'b0;
    mode_usage_en = 1'b0;
    ev = 5'h00;
    inq_avail = 1'b1;
    inq_wr_en = 1'b0;
    inq_wr_addr = 6'h00;
    inq_wr_data = 8'h00;
    sense_taken = 1'b0;
    slow = 1'b0;
    ops = '{dbcd_pkg::OP_READ, dbcd_pkg::OP_WRITE, dbcd_pkg::OP_SEEK};
    alen[6] = $random(seed) & 255;
    repeat (5) @(negedge mclk);
    srst = 1'b0;
    chk(usage_en, 0);
    for (int i = 0; i < 58; i++) begin
      @(negedge mclk);
      inq_wr_en = 1'b1;
      inq_wr_addr = 6'(i);
      inq_wr_data = 8'($random(seed));
      mem[i] = inq_wr_data;
    end
    @(negedge mclk);
    inq_wr_en = 1'b0;
    foreach (alen[j]) begin
      run({dbcd_pkg::OP_INQUIRY, 24'h0, 8'(alen[j]), 8'h00});
      len = exp_inq(alen[j]);
      chk(got.size(), len);
      foreach (got[k])
        chk(got[k], mem[k]);
      chk(cmd_check, 0);
    end
    inq_avail = 1'b0;
    run({dbcd_pkg::OP_INQUIRY, 24'h0, 8'h09, 8'h00});
    chk(cmd_check, 1);
    chk(got.size(), 0);
    inq_avail = 1'b1;
    run({8'hC5, 40'h0});
    chk(cmd_check, 1);
    chk(nblk + got.size(), 0);
    for (int i = 0; i < 9; i++) begin
      len = i < 3 ? 0 : i < 6 ? 1 : $random(seed);
      blk(ops[i % 3], 8'(len));
    end
    report(exp_cnt);
    pulse(40, 5'h00, 5'h1F);
    report(exp_cnt);
    exp_cnt = 72'h0;
    report(exp_cnt);
    pulse(256, 5'h04, 5'h01);
    blk(dbcd_pkg::OP_SEEK, 8'h00);
    chk(sense_valid, 0);
    mode_usage_en = 1'b1;
    mode_wr = 1'b1;
    @(negedge mclk);
    mode_wr = 1'b0;
    chk(usage_en, 1);
    run({dbcd_pkg::OP_SEEK, 40'h0});
    chk(cmd_check, 1);
    chk(nblk, 0);
    chk(sense_valid, 1);
    chk(sense_cnt, exp_cnt);
    sense_taken = 1'b1;
    @(negedge mclk);
    sense_taken = 1'b0;
    chk(sense_valid, 0);
    exp_cnt = 72'h0;
    report(exp_cnt);
    give_verdict();
  end
endmodule
